//--- src/bfs_freq_select.sv
// bus frequency select driver: chooses the bus code and drives it on open-drain pins
// Function
// - terminated bus group is launched and sampled on the system bus clock only.
// - cmos, clock, interrupt bus and test inputs arrive asynchronously; synchronise them.
// - interrupt serial bus signals are timed by the interrupt bus clock.
// - test access port signals are timed by the test clock.
// - during power-up the select pins may be indeterminate briefly.
// - once termination power good is seen, select pins hold their final value.
// - the device chooses the frequency and drives the code to the platform.
`timescale 1ns/10ps
`include "bfs_map.svh"
module bfs_freq_select #(
    parameter bfs_pkg::bfs_code_t FREQ_CODE     = `BFS_CODE_100MHZ,
    parameter int                 SETTLE_CYCLES = `BFS_SETTLE_CYCLES,
    parameter int                 FAULT_CYCLES  = `BFS_FAULT_CYCLES
) (
    input  wire logic               i_clock,
    input  wire logic               i_rst_n,
    input  wire logic               i_termination_power_good,
    input  wire logic               i_interrupt_bus_clock,
    input  wire logic               i_test_clock,
    input  wire bfs_pkg::bfs_code_t i_bus_freq_select_i,
    input  wire logic               i_terminated_bus_group,
    output bfs_pkg::bfs_code_t      o_bus_freq_select_o,
    output bfs_pkg::bfs_code_t      o_bus_freq_select_oe_n,
    output logic                    o_select_final,
    output logic                    o_power_good_seen,
    output logic                    o_code_reserved,
    output logic                    o_readback_fault,
    output logic                    o_interrupt_bus_tick,
    output logic                    o_test_tick,
    output logic                    o_terminated_bus_group
);
    import bfs_pkg::*;

    localparam logic [3:0] SETTLE_LAST = 4'(SETTLE_CYCLES - 1);
    localparam logic [3:0] FAULT_LAST  = 4'(FAULT_CYCLES - 1);

    logic [`BFS_SYNC_WIDTH-1:0] sync_in;
    logic [`BFS_SYNC_WIDTH-1:0] sync_out;
    logic                       power_good_s;
    logic                       int_clock_s;
    logic                       test_clock_s;
    bfs_code_t                  readback_s;

    // every asynchronous input passes two flops before any logic sees it
    assign sync_in = {i_bus_freq_select_i, i_test_clock, i_interrupt_bus_clock,
                      i_termination_power_good};

    bfs_sync #(
        .WIDTH  (`BFS_SYNC_WIDTH),
        .STAGES (`BFS_SYNC_STAGES)
    ) u_sync (
        .i_clock (i_clock),
        .i_rst_n (i_rst_n),
        .i_async (sync_in),
        .o_sync  (sync_out)
    );

    assign power_good_s = sync_out[`BFS_SYNC_POWER_GOOD];
    assign int_clock_s  = sync_out[`BFS_SYNC_INT_CLOCK];
    assign test_clock_s = sync_out[`BFS_SYNC_TEST_CLOCK];
    assign readback_s   = sync_out[`BFS_SYNC_READBACK_LO +: `BFS_CODE_WIDTH];

    // select pin sequencer: pins released, a settle wait, then a code
    // frozen until the next reset; power good cuts the wait short
    bfs_state_e state;
    bfs_state_e next_state;
    logic [3:0] settle_count;
    logic [3:0] next_settle_count;
    bfs_code_t  pin_out;
    bfs_code_t  next_pin_out;
    bfs_code_t  pin_oe_n;
    bfs_code_t  next_pin_oe_n;
    logic       final_flag;
    logic       next_final_flag;
    logic       pg_seen;
    logic       next_pg_seen;
    logic       reserved;
    logic       next_reserved;

    always_comb begin
        next_state        = state;
        next_settle_count = settle_count;
        next_pin_out      = `BFS_RST_PIN_OUT;
        next_pin_oe_n     = pin_oe_n;
        next_final_flag   = final_flag;
        next_pg_seen      = pg_seen | power_good_s;
        next_reserved     = bfs_is_reserved(FREQ_CODE);
        case (state)
            BFS_POWERUP: begin
                // pins float to the pull-ups until the driver is enabled
                next_pin_oe_n     = `BFS_RST_PIN_OE_N;
                next_settle_count = `BFS_RST_COUNT;
                next_state        = BFS_SETTLE;
            end
            BFS_SETTLE: begin
                // code bits at 0 are pulled down, code bits at 1 released to the pull-up
                next_pin_oe_n = FREQ_CODE;
                if (power_good_s || settle_count == SETTLE_LAST) begin
                    next_state      = BFS_FINAL;
                    next_final_flag = 1'b1;
                end else begin
                    next_settle_count = settle_count + 4'h1;
                end
            end
            BFS_FINAL: begin
                // the code is frozen here until the next reset
                next_pin_oe_n   = FREQ_CODE;
                next_final_flag = 1'b1;
            end
            default: begin
                next_state    = BFS_POWERUP;
                next_pin_oe_n = `BFS_RST_PIN_OE_N;
            end
        endcase
    end

    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            state        <= BFS_POWERUP;
            settle_count <= `BFS_RST_COUNT;
            pin_out      <= `BFS_RST_PIN_OUT;
            pin_oe_n     <= `BFS_RST_PIN_OE_N;
            final_flag   <= `BFS_RST_FLAG;
            pg_seen      <= `BFS_RST_FLAG;
            reserved     <= `BFS_RST_FLAG;
        end else begin
            state        <= next_state;
            settle_count <= next_settle_count;
            pin_out      <= next_pin_out;
            pin_oe_n     <= next_pin_oe_n;
            final_flag   <= next_final_flag;
            pg_seen      <= next_pg_seen;
            reserved     <= next_reserved;
        end
    end

    // readback check: a pin that disagrees with the driven code for too
    // long means a board fault (short or missing pull-up)
    logic [3:0] fault_count;
    logic [3:0] next_fault_count;
    logic       fault;
    logic       next_fault;

    always_comb begin
        next_fault_count = `BFS_RST_COUNT;
        next_fault       = fault;
        if (final_flag && pg_seen && readback_s != FREQ_CODE) begin
            if (fault_count == FAULT_LAST) begin
                next_fault       = 1'b1;
                next_fault_count = fault_count;
            end else begin
                next_fault_count = fault_count + 4'h1;
            end
        end
    end

    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            fault_count <= `BFS_RST_COUNT;
            fault       <= `BFS_RST_FLAG;
        end else begin
            fault_count <= next_fault_count;
            fault       <= next_fault;
        end
    end

    // clock-relation helpers: rising edges of the side clocks, and the
    // terminated group registered on the bus clock
    logic int_clock_d;
    logic next_int_clock_d;
    logic test_clock_d;
    logic next_test_clock_d;
    logic int_tick;
    logic next_int_tick;
    logic test_tick;
    logic next_test_tick;
    logic term_bus;
    logic next_term_bus;

    always_comb begin
        next_int_clock_d  = int_clock_s;
        next_test_clock_d = test_clock_s;
        next_int_tick     = int_clock_s & ~int_clock_d;
        next_test_tick    = test_clock_s & ~test_clock_d;
        next_term_bus     = i_terminated_bus_group;
    end

    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            int_clock_d  <= `BFS_RST_FLAG;
            test_clock_d <= `BFS_RST_FLAG;
            int_tick     <= `BFS_RST_FLAG;
            test_tick    <= `BFS_RST_FLAG;
            term_bus     <= `BFS_RST_FLAG;
        end else begin
            int_clock_d  <= next_int_clock_d;
            test_clock_d <= next_test_clock_d;
            int_tick     <= next_int_tick;
            test_tick    <= next_test_tick;
            term_bus     <= next_term_bus;
        end
    end

    assign o_bus_freq_select_o    = pin_out;
    assign o_bus_freq_select_oe_n = pin_oe_n;
    assign o_select_final         = final_flag;
    assign o_power_good_seen      = pg_seen;
    assign o_code_reserved        = reserved;
    assign o_readback_fault       = fault;
    assign o_interrupt_bus_tick   = int_tick;
    assign o_test_tick            = test_tick;
    assign o_terminated_bus_group = term_bus;

endmodule : bfs_freq_select

//--- src/bfs_map.svh
// constants for the bus frequency select driver: codes, reset values and timing
`ifndef BFS_MAP_SVH
`define BFS_MAP_SVH

`define BFS_CLOCK_PERIOD_NS   40
`define BFS_SETTLE_NS         200
`define BFS_SETTLE_CYCLES     ((`BFS_SETTLE_NS + `BFS_CLOCK_PERIOD_NS - 1) / `BFS_CLOCK_PERIOD_NS)
`define BFS_FAULT_NS          120
`define BFS_FAULT_CYCLES      ((`BFS_FAULT_NS + `BFS_CLOCK_PERIOD_NS - 1) / `BFS_CLOCK_PERIOD_NS)
`define BFS_SYNC_STAGES       2

`define BFS_CODE_WIDTH        2
`define BFS_CODE_100MHZ       2'h1
`define BFS_CODE_HI_BIT       1
`define BFS_CODE_LO_BIT       0

`define BFS_RST_PIN_OUT       2'h0
`define BFS_RST_PIN_OE_N      2'h3
`define BFS_RST_FLAG          1'h0
`define BFS_RST_COUNT         4'h0

`define BFS_SYNC_POWER_GOOD   0
`define BFS_SYNC_INT_CLOCK    1
`define BFS_SYNC_TEST_CLOCK   2
`define BFS_SYNC_READBACK_LO  3
`define BFS_SYNC_WIDTH        5

`endif

//--- src/bfs_pkg.sv
// types and the code decoder shared by the bus frequency select driver
package bfs_pkg;

    typedef logic [1:0] bfs_code_t;

    typedef enum logic [1:0] {
        BFS_POWERUP = 2'b00,
        BFS_SETTLE  = 2'b01,
        BFS_FINAL   = 2'b10
    } bfs_state_e;

    // only the low-bit-set, high-bit-clear code names a rated frequency
    function automatic logic bfs_is_reserved(input bfs_code_t code);
        bfs_is_reserved = !(code[1] == 1'b0 && code[0] == 1'b1);
    endfunction : bfs_is_reserved

endpackage : bfs_pkg

//--- src/bfs_sync.sv
// two-flop synchronisers for inputs that bear no phase relation to the bus clock
`timescale 1ns/10ps
module bfs_sync #(
    parameter int WIDTH  = 1,
    parameter int STAGES = 2
) (
    input  wire logic             i_clock,
    input  wire logic             i_rst_n,
    input  wire logic [WIDTH-1:0] i_async,
    output logic      [WIDTH-1:0] o_sync
);

    genvar g;
    generate
        for (g = 0; g < WIDTH; g = g + 1) begin : g_bit
            logic [STAGES-1:0] chain;
            logic [STAGES-1:0] next_chain;
            always_comb begin
                next_chain = {chain[STAGES-2:0], i_async[g]};
            end
            always_ff @(posedge i_clock) begin
                if (!i_rst_n) begin
                    chain <= '0;
                end else begin
                    chain <= next_chain;
                end
            end
            assign o_sync[g] = chain[STAGES-1];
        end
    endgenerate

endmodule : bfs_sync

//--- testbench/bfs_freq_select_props.sv
// port assertions for the bus frequency select driver
`timescale 1ns/10ps
module bfs_freq_select_props #(
    parameter bfs_pkg::bfs_code_t FREQ_CODE = 2'h1
) (
    input wire logic               i_clock,
    input wire logic               i_rst_n,
    input wire logic               i_interrupt_bus_clock,
    input wire logic               i_terminated_bus_group,
    input wire bfs_pkg::bfs_code_t o_bus_freq_select_o,
    input wire bfs_pkg::bfs_code_t o_bus_freq_select_oe_n,
    input wire logic               o_select_final,
    input wire logic               o_power_good_seen,
    input wire logic               o_code_reserved,
    input wire logic               o_interrupt_bus_tick,
    input wire logic               o_test_tick,
    input wire logic               o_terminated_bus_group
);
    import bfs_pkg::*;
    default clocking @(posedge i_clock); endclocking
    default disable iff (!i_rst_n);
    pins_hold_a: assert property (o_select_final |=> $stable(o_bus_freq_select_oe_n))
        else $error("select pins moved after final");
    final_code_a: assert property (o_select_final |-> o_bus_freq_select_oe_n == FREQ_CODE)
        else $error("final code wrong");
    drive_low_a: assert property (o_bus_freq_select_o == 2'h0)
        else $error("open drain data not low");
    pg_final_a: assert property (o_power_good_seen |-> ##[0:1] o_select_final)
        else $error("power good seen but code not final");
    reserved_a: assert property ($past(i_rst_n) |-> o_code_reserved == (FREQ_CODE != 2'h1))
        else $error("reserved flag wrong");
    group_a: assert property ($past(i_rst_n) |-> o_terminated_bus_group == $past(i_terminated_bus_group))
        else $error("terminated group not one clock late");
    itick_pulse_a: assert property (o_interrupt_bus_tick |=> !o_interrupt_bus_tick)
        else $error("interrupt tick too long");
    ttick_pulse_a: assert property (o_test_tick |=> !o_test_tick)
        else $error("test tick too long");
    itick_cause_a: assert property (o_interrupt_bus_tick |-> $past(i_interrupt_bus_clock, 2))
        else $error("interrupt tick without clock edge");
endmodule : bfs_freq_select_props

bind bfs_freq_select bfs_freq_select_props #(.FREQ_CODE(FREQ_CODE)) u_props (
    .i_clock(i_clock), .i_rst_n(i_rst_n), .i_interrupt_bus_clock(i_interrupt_bus_clock),
    .i_terminated_bus_group(i_terminated_bus_group), .o_bus_freq_select_o(o_bus_freq_select_o),
    .o_bus_freq_select_oe_n(o_bus_freq_select_oe_n), .o_select_final(o_select_final),
    .o_power_good_seen(o_power_good_seen), .o_code_reserved(o_code_reserved),
    .o_interrupt_bus_tick(o_interrupt_bus_tick), .o_test_tick(o_test_tick),
    .o_terminated_bus_group(o_terminated_bus_group));

//--- testbench/bfs_freq_select_tb_top.sv
// testbench for the bus frequency select driver with the platform model
`timescale 1ns/10ps
module bfs_freq_select_tb_top;
    import bfs_pkg::*;
    logic       i_clock, i_rst_n, pg, iclk, tclk, grp, ovr_en;
    logic       fin, pg_seen, rsv, fault, itick, ttick, o_grp, p_lat, p_rsv;
    bfs_code_t  ovr, pin, o_sel, oe_n, p_code;
    logic [7:0] p_mhz;
    int         n_fail, tests_run, n_itick, n_ttick;
    // pull-up holds released bits high; ovr forces a chosen level on the wire
    assign pin = ovr_en ? ovr : (o_sel | oe_n);
    bfs_freq_select #(.FREQ_CODE(2'h1), .SETTLE_CYCLES(5), .FAULT_CYCLES(3)) uut (
        .i_clock(i_clock), .i_rst_n(i_rst_n), .i_termination_power_good(pg),
        .i_interrupt_bus_clock(iclk), .i_test_clock(tclk), .i_bus_freq_select_i(pin),
        .i_terminated_bus_group(grp), .o_bus_freq_select_o(o_sel),
        .o_bus_freq_select_oe_n(oe_n), .o_select_final(fin), .o_power_good_seen(pg_seen),
        .o_code_reserved(rsv), .o_readback_fault(fault), .o_interrupt_bus_tick(itick),
        .o_test_tick(ttick), .o_terminated_bus_group(o_grp));
    bfs_platform_model u_plat (.i_clock(i_clock), .i_rst_n(i_rst_n),
        .i_termination_power_good(pg), .i_bus_freq_select(pin), .o_code(p_code),
        .o_latched(p_lat), .o_reserved(p_rsv), .o_mhz(p_mhz));
    initial begin
        i_clock = 1'b0;
        forever #20 i_clock = ~i_clock;
    end
    always @(posedge i_clock) begin
        n_itick += int'(itick === 1'b1);
        n_ttick += int'(ttick === 1'b1);
    end
    task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string msg);
        tests_run++;
        if (seen !== exp) begin
            n_fail++;
            $display("BAD %0t %s", $time, msg);
        end
    endtask : check
    task automatic step(input int n);
        repeat (n) @(posedge i_clock);
        #1;
    endtask : step
    task automatic do_reset(input logic pg_v);
        @(posedge i_clock) i_rst_n <= 1'b0;
        pg <= pg_v;
        repeat (4) @(posedge i_clock);
        i_rst_n <= 1'b1;
        step(1);
    endtask : do_reset
    task automatic t_walk();
        do_reset(1'b0);
        check(oe_n, 2'h3, "pins not released early");
        step(1);
        check(pin, 2'h1, "wire code");
        step(3);
        check(fin, 1'b0, "final too soon");
        step(1);
        check(fin, 1'b1, "final late");
        check(p_lat, 1'b0, "platform latched early");
    endtask : t_walk
    task automatic t_power();
        @(posedge i_clock) pg <= 1'b1;
        step(5);
        check(pg_seen, 1'b1, "power good not seen");
        check(p_code, 2'h1, "latched code");
        check(p_mhz, 8'h64, "bus rate");
        check(rsv, 1'b0, "reserved flag");
        @(posedge i_clock) pg <= 1'b0;
        step(6);
        check(pg_seen, 1'b1, "power good not sticky");
        check(oe_n, 2'h1, "pins moved");
        check(p_code, 2'h1, "latch lost");
    endtask : t_power
    task automatic t_early();
        do_reset(1'b1);
        step(1);
        check(fin, 1'b0, "final before power good");
        step(1);
        check(fin, 1'b1, "no early final");
        check(oe_n, 2'h1, "early code");
        step(3);
        check(fault, 1'b0, "readback glitch flagged");
    endtask : t_early
    task automatic t_codes();
        for (int c = 0; c < 4; c++) begin
            @(posedge i_clock) ovr <= 2'(c);
            ovr_en <= 1'b1;
            do_reset(1'b0);
            @(posedge i_clock) pg <= 1'b1;
            step(16);
            check(p_rsv, 8'(c != 1), "decode");
            check(p_code, 8'(c), "latched wire");
            check(fault, 8'(c != 1), "readback fault");
        end
        @(posedge i_clock) ovr_en <= 1'b0;
    endtask : t_codes
    task automatic t_group();
        logic [8:0] pat;
        pat = 9'h0b5;
        for (int i = 0; i < 9; i++) begin
            @(posedge i_clock) grp <= pat[i];
            #1;
            if (i > 0) check(o_grp, pat[i-1], "group delay");
        end
    endtask : t_group
    task automatic t_ticks();
        n_itick = 0;
        n_ttick = 0;
        repeat (3) begin
            @(posedge i_clock) iclk <= 1'b1;
            tclk <= 1'b1;
            step(5);
            @(posedge i_clock) iclk <= 1'b0;
            tclk <= 1'b0;
            step(5);
        end
        step(6);
        check(8'(n_itick), 8'h03, "interrupt ticks");
        check(8'(n_ttick), 8'h03, "test ticks");
    endtask : t_ticks
    task automatic end_sim();
        $display("failures %0d of %0d checks", n_fail, tests_run);
        if (n_fail == 0 && tests_run > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : end_sim
    initial begin
        #(40 * 3000);
        n_fail++;
        end_sim();
    end
    initial begin
        {i_rst_n, pg, iclk, tclk, grp, ovr_en, ovr} <= 8'h00;
        t_walk();
        t_power();
        t_early();
        t_codes();
        t_group();
        t_ticks();
        end_sim();
    end
endmodule : bfs_freq_select_tb_top

//--- testbench/bfs_platform_model.sv
// platform model: latches and decodes the select code once power good is up
`timescale 1ns/10ps
module bfs_platform_model (
    input  wire logic               i_clock,
    input  wire logic               i_rst_n,
    input  wire logic               i_termination_power_good,
    input  wire bfs_pkg::bfs_code_t i_bus_freq_select,
    output bfs_pkg::bfs_code_t      o_code,
    output logic                    o_latched,
    output logic                    o_reserved,
    output logic [7:0]              o_mhz
);
    import bfs_pkg::*;
    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            o_latched  <= 1'b0;
            o_code     <= 2'h0;
            o_reserved <= 1'b0;
            o_mhz      <= 8'h00;
        end else if (i_termination_power_good && !o_latched) begin
            o_latched  <= 1'b1;
            o_code     <= i_bus_freq_select;
            o_reserved <= (i_bus_freq_select != 2'h1);
            o_mhz      <= (i_bus_freq_select == 2'h1) ? 8'h64 : 8'h00;
        end
    end
endmodule : bfs_platform_model
